// ---- logic/olcc_checker.sv ----
`timescale 1ns/1ns
// How it works
// - factory mirror array is checked with a three-bit cyclic code.
// - factory check only runs while the factory lock is active.
// - lock active only when fuse lock and readout mirror lock both read one.
// - fuse-to-mirror readout happens after reset or a bus clear command.
// - factory code covers serial bytes, low six type bits, factory config bits.
// - stored factory code and factory lock bit are left out of the code.
// - bits enter lsb first, registers in ascending address order.
// - generator x^3+x+1, register seeded with all ones each time.
// - computed factory code differing from stored field sets the data error.
// - both checks read the mirror registers, never the fuse inputs.
// - user array checked on its own, only while the user lock is active.
// - setting the user lock computes the user code and stores it.
// - user code is recomputed continuously and compared with the stored one.
// - user writes update mirrors and computed code whatever the lock state.
// - user mismatch ignored while the user lock is inactive.
// - hold reset until supplies settle, reassert when any supply drops.
// - at a fixed rate both regulators are disabled together briefly.
// - single-bit converter stream is passed on at a nominal 1 MHz.
module olcc_checker #(
    parameter int SETTLE_CYCLES = olcc_pkg::SETTLE_CYC,
    parameter int CAPTEST_RATE  = olcc_pkg::CAPTEST_RATE_CYC
) (
    input  wire logic                clk,
    input  wire logic                rst,
    // classic wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [6:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // fuse array contents
    input  wire olcc_pkg::olcc_fuse_t fuseImage,
    // supply monitors, high when above threshold
    input  wire logic                reservoirSupplyOk,
    input  wire logic                vregOk,
    input  wire logic                vregaOk,
    // converter bit stream
    input  wire logic                sdBitIn,
    output logic                     sdBitOut,
    output logic                     sdBitValid,
    // status toward the sensor bus logic
    output logic                     dataError,
    output logic                     deviceReset,
    output logic                     regulatorsOff
);
    import olcc_pkg::*;

    // sequencer and mirror
    olcc_state_t  state_r;
    olcc_fuse_t   mirror_r;
    logic         facLockActive_r;
    logic         usrLockActive_r;
    logic         dataError_r;
    logic         lockStore_r;
    logic         ack_r;
    logic [31:0]  rdData_r;

    // supply and cap test
    logic [2:0]   supSync1_r, supSync2_r, supSync3_r;
    logic [2:0]   supLevel_r;
    logic [31:0]  settleCnt_r;
    logic         holdReset_r;
    logic [31:0]  capRateCnt_r;
    logic [7:0]   capTimeCnt_r;
    logic         regOff_r;

    // converter stream
    logic [7:0]   sdDivCnt_r;
    logic         sdSync1_r, sdSync2_r, sdSync3_r;
    logic         sdLevel_r;
    logic         sdBit_r;
    logic         sdValid_r;

    // decode and codes
    logic         clearCmd;
    logic         busWrite;
    logic         checking;
    logic [2:0]   facCrc;
    logic [2:0]   usrCrc;
    logic         facMismatch;
    logic         usrMismatch;
    logic [FAC_BITS-1:0] facBits;
    logic [USR_BITS-1:0] usrBits;
    logic [4:0]   wordIdx;
    olcc_status_t status;

    // serial cyclic code, bit 0 of the vector enters first
    function automatic logic [2:0] crc3(input logic [USR_BITS-1:0] bits, input int count);
        logic [2:0] crc;
        logic       fb;
        crc = CRC_SEED;
        fb  = 1'b0;
        // fixed bound, stop at count
        for (int i = 0; i < USR_BITS; i++) begin
            if (i < count) begin
                fb  = crc[2] ^ bits[i];
                crc = {crc[1], crc[0] ^ fb, fb};
            end
        end
        return crc;
    endfunction : crc3

    // code inputs taken from the mirror, lowest address and lsb first
    assign facBits = {mirror_r.factoryCfg, mirror_r.typeReg[5:0],
                      mirror_r.serialNumber[3], mirror_r.serialNumber[2],
                      mirror_r.serialNumber[1], mirror_r.serialNumber[0]};
    assign usrBits = {mirror_r.userDataBytes[7], mirror_r.userDataBytes[6],
                      mirror_r.userDataBytes[5], mirror_r.userDataBytes[4],
                      mirror_r.userDataBytes[3], mirror_r.userDataBytes[2],
                      mirror_r.userDataBytes[1], mirror_r.userDataBytes[0],
                      mirror_r.deviceConfig2[5], mirror_r.deviceConfig2[3:0],
                      mirror_r.deviceConfig1[1:0], mirror_r.deviceConfig0[7],
                      mirror_r.typeReg[7:6]};

    // continuous recomputation of both codes
    assign facCrc = crc3({{(USR_BITS-FAC_BITS){1'b0}}, facBits}, FAC_BITS);
    assign usrCrc = crc3(usrBits, USR_BITS);

    // comparisons, qualified by the active locks
    assign checking    = (state_r == ST_RUN);
    assign facMismatch = checking && facLockActive_r
                         && (facCrc != mirror_r.factoryCrc);
    assign usrMismatch = checking && usrLockActive_r && !lockStore_r
                         && (usrCrc != mirror_r.userCode);

    // bus decode
    assign wordIdx  = wb_adr_i[6:2];
    assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];
    // clear only in run, not mid-readout
    assign clearCmd = busWrite && checking && (wordIdx == IDX_CTRL) && wb_dat_i[CTRL_CLEAR_BIT];

    assign status = '{readoutBusy:       !checking,
                      userMismatch:      usrMismatch,
                      factoryMismatch:   facMismatch,
                      userLockActive:    usrLockActive_r,
                      factoryLockActive: facLockActive_r,
                      dataError:         dataError_r};

    // supply monitor synchronisers, a change counts once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            supSync1_r <= 3'h0;
            supSync2_r <= 3'h0;
            supSync3_r <= 3'h0;
            supLevel_r <= 3'h0;
        end else begin
            supSync1_r <= {vregaOk, vregOk, reservoirSupplyOk};
            supSync2_r <= supSync1_r;
            supSync3_r <= supSync2_r;
            for (int i = 0; i < 3; i++) begin
                if (supSync2_r[i] == supSync3_r[i]) begin
                    supLevel_r[i] <= supSync3_r[i];
                end
            end
        end
    end

    // reset hold until all supplies have stayed good for the settle time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settleCnt_r <= 32'h0;
            holdReset_r <= 1'b1;
        end else if (supLevel_r != 3'h7) begin
            settleCnt_r <= 32'h0;
            holdReset_r <= 1'b1;
        end else if (settleCnt_r < 32'(SETTLE_CYCLES)) begin
            settleCnt_r <= settleCnt_r + 32'h1;
        end else begin
            holdReset_r <= 1'b0;
        end
    end

    // capacitor test: regulators switched off together at a fixed rate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capRateCnt_r <= 32'h0;
            capTimeCnt_r <= 8'h0;
            regOff_r     <= 1'b0;
        end else if (capRateCnt_r >= 32'(CAPTEST_RATE - 1)) begin
            capRateCnt_r <= 32'h0;
            capTimeCnt_r <= 8'(CAPTEST_TIME_CYC);
            regOff_r     <= 1'b1;
        end else begin
            capRateCnt_r <= capRateCnt_r + 32'h1;
            // pulse width counts down
            if (capTimeCnt_r > 8'h1) begin
                capTimeCnt_r <= capTimeCnt_r - 8'h1;
            end else begin
                capTimeCnt_r <= 8'h0;
                regOff_r     <= 1'b0;
            end
        end
    end

    // converter bit synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdSync1_r <= 1'b0;
            sdSync2_r <= 1'b0;
            sdSync3_r <= 1'b0;
            sdLevel_r <= 1'b0;
        end else begin
            sdSync1_r <= sdBitIn;
            sdSync2_r <= sdSync1_r;
            sdSync3_r <= sdSync2_r;
            if (sdSync2_r == sdSync3_r) begin
                sdLevel_r <= sdSync3_r;
            end
        end
    end

    // 1 MHz stream: one bit every divider period, with a valid pulse only while reset is not held
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdDivCnt_r <= 8'h0;
            sdBit_r    <= 1'b0;
            sdValid_r  <= 1'b0;
        end else if (sdDivCnt_r == 8'(SD_DIV_CYC - 1)) begin
            sdDivCnt_r <= 8'h0;
            sdBit_r    <= sdLevel_r;
            sdValid_r  <= !holdReset_r;
        end else begin
            sdDivCnt_r <= sdDivCnt_r + 8'h1;
            sdValid_r  <= 1'b0;
        end
    end

    // readout sequencer: hold, copy fuses, let codes settle, then check
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_HOLD;
        end else if (holdReset_r) begin
            state_r <= ST_HOLD;
        end else begin
            case (state_r)
                ST_HOLD: begin
                    state_r <= ST_LOAD;
                end
                ST_LOAD: begin
                    state_r <= ST_SETTLE;
                end
                // codes follow the mirror
                ST_SETTLE: begin
                    state_r <= ST_RUN;
                end
                ST_RUN: begin
                    if (clearCmd) begin
                        state_r <= ST_LOAD;
                    end
                end
                default: begin
                    state_r <= ST_HOLD;
                end
            endcase
        end
    end

    // lock activity is decided only at readout
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            facLockActive_r <= 1'b0;
            usrLockActive_r <= 1'b0;
        end else if (state_r == ST_HOLD) begin
            facLockActive_r <= 1'b0;
            usrLockActive_r <= 1'b0;
        end else if (state_r == ST_LOAD) begin
            // any zero bit keeps the lock off
            facLockActive_r <= fuseImage.factoryLock && mirror_r.factoryLock;
            usrLockActive_r <= fuseImage.deviceConfig2[CFG2_LOCKU_BIT]
                               && mirror_r.deviceConfig2[CFG2_LOCKU_BIT];
        end
    end

    // mirror registers: loaded from fuses at readout, user part written over the bus
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mirror_r    <= FUSE_RESET;
            lockStore_r <= 1'b0;
        end else if (state_r == ST_HOLD) begin
            mirror_r    <= fuseImage;
            lockStore_r <= 1'b0;
        end else if (clearCmd) begin
            mirror_r    <= fuseImage;
            lockStore_r <= 1'b0;
        end else begin
            lockStore_r <= 1'b0;
            if (lockStore_r) begin
                mirror_r.userCode <= usrCrc;
            end
            // user words, run only
            if (busWrite && checking) begin
                case (wordIdx)
                    IDX_TYPE: mirror_r.typeReg[7:6]     <= wb_dat_i[7:6];
                    IDX_CFG0: mirror_r.deviceConfig0[7] <= wb_dat_i[7];
                    IDX_CFG1: mirror_r.deviceConfig1    <= {6'h00, wb_dat_i[1:0]};
                    IDX_CFG2: begin
                        mirror_r.deviceConfig2 <= {wb_dat_i[7], 1'b0, wb_dat_i[5], 1'b0, wb_dat_i[3:0]};
                        lockStore_r <= wb_dat_i[CFG2_LOCKU_BIT];
                    end
                    default: begin
                        if (wordIdx >= IDX_UDATA0 && wordIdx < IDX_UCODE) begin
                            mirror_r.userDataBytes[3'(wordIdx - IDX_UDATA0)] <= wb_dat_i[7:0];
                        end
                    end
                endcase
            end
        end
    end

    // sticky data error, only a readout clears it, a new mismatch wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dataError_r <= 1'b0;
        end else if (facMismatch || usrMismatch) begin
            dataError_r <= 1'b1;
        end else if (state_r == ST_LOAD) begin
            dataError_r <= 1'b0;
        end
    end

    // bus ack, one wait state, dropped the cycle after it was given
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    // read data captured as ack rises, unmapped words read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_r <= 32'h0;
        end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
            rdData_r <= 32'h0;
            case (wordIdx)
                IDX_STATUS: rdData_r <= {26'h0, status};
                IDX_TYPE:   rdData_r <= {24'h0, mirror_r.typeReg};
                IDX_FCFG:   rdData_r <= {24'h0, mirror_r.factoryCfg};
                IDX_FLOCK:  rdData_r <= {24'h0, mirror_r.factoryLock, 4'h0, mirror_r.factoryCrc};
                IDX_CFG0:   rdData_r <= {24'h0, mirror_r.deviceConfig0};
                IDX_CFG1:   rdData_r <= {24'h0, mirror_r.deviceConfig1};
                IDX_CFG2:   rdData_r <= {24'h0, mirror_r.deviceConfig2};
                IDX_UCODE:  rdData_r <= {29'h0, mirror_r.userCode};
                IDX_CALC:   rdData_r <= {21'h0, usrCrc, 5'h00, facCrc};
                default: begin
                    if (wordIdx >= IDX_SERIAL0 && wordIdx < IDX_TYPE) begin
                        rdData_r <= {24'h0, mirror_r.serialNumber[2'(wordIdx - IDX_SERIAL0)]};
                    end else if (wordIdx >= IDX_UDATA0 && wordIdx < IDX_UCODE) begin
                        rdData_r <= {24'h0, mirror_r.userDataBytes[3'(wordIdx - IDX_UDATA0)]};
                    end
                end
            endcase
        end
    end

    // outputs straight from flip-flops
    assign wb_ack_o      = ack_r;
    assign wb_dat_o      = rdData_r;
    assign dataError     = dataError_r;
    assign deviceReset   = holdReset_r;
    assign regulatorsOff = regOff_r;
    assign sdBitOut      = sdBit_r;
    assign sdBitValid    = sdValid_r;

endmodule : olcc_checker

// ---- logic/olcc_pkg.sv ----
package olcc_pkg;

    // clock and timing
    localparam int CLK_HZ           = 50_000_000;
    localparam int SD_RATE_HZ       = 1_000_000;
    localparam int SD_DIV_CYC       = CLK_HZ / SD_RATE_HZ;
    localparam int SETTLE_US        = 100;
    localparam int SETTLE_CYC       = SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int CAPTEST_RATE_US  = 1000;
    localparam int CAPTEST_RATE_CYC = CAPTEST_RATE_US * (CLK_HZ / 1_000_000);
    localparam int CAPTEST_TIME_US  = 2;
    localparam int CAPTEST_TIME_CYC = CAPTEST_TIME_US * (CLK_HZ / 1_000_000);

    // check code
    localparam logic [2:0] CRC_SEED   = 3'h7;
    localparam int         FAC_BITS   = 46;
    localparam int         USR_BITS   = 74;

    // register word indices, byte address is four times the index
    localparam logic [4:0] IDX_CTRL    = 5'h00;
    localparam logic [4:0] IDX_STATUS  = 5'h01;
    localparam logic [4:0] IDX_SERIAL0 = 5'h02;
    localparam logic [4:0] IDX_TYPE    = 5'h06;
    localparam logic [4:0] IDX_FCFG    = 5'h07;
    localparam logic [4:0] IDX_FLOCK   = 5'h08;
    localparam logic [4:0] IDX_CFG0    = 5'h09;
    localparam logic [4:0] IDX_CFG1    = 5'h0A;
    localparam logic [4:0] IDX_CFG2    = 5'h0B;
    localparam logic [4:0] IDX_UDATA0  = 5'h0C;
    localparam logic [4:0] IDX_UCODE   = 5'h14;
    localparam logic [4:0] IDX_CALC    = 5'h15;

    // field positions
    localparam int CTRL_CLEAR_BIT = 0;
    localparam int CFG2_LOCKU_BIT = 7;

    // fuse image, one copy in fuses and one in the mirror
    typedef struct packed {
        logic [3:0][7:0] serialNumber;   // serial_number_byte3..0
        logic [7:0]      typeReg;
        logic [7:0]      factoryCfg;
        logic [2:0]      factoryCrc;
        logic            factoryLock;
        logic [7:0]      deviceConfig0;  // identity_select_bit at [7]
        logic [7:0]      deviceConfig1;  // attribute_bits at [1:0]
        logic [7:0]      deviceConfig2;  // user lock [7], output enable [5], address [3:0]
        logic [7:0][7:0] userDataBytes;
        logic [2:0]      userCode;
    } olcc_fuse_t;

    localparam olcc_fuse_t FUSE_RESET = '0;

    // status word
    typedef struct packed {
        logic       readoutBusy;
        logic       userMismatch;
        logic       factoryMismatch;
        logic       userLockActive;
        logic       factoryLockActive;
        logic       dataError;
    } olcc_status_t;

    typedef enum logic [3:0] {
        ST_HOLD   = 4'h1,
        ST_LOAD   = 4'h2,
        ST_SETTLE = 4'h4,
        ST_RUN    = 4'h8
    } olcc_state_t;

endpackage : olcc_pkg

// ---- test/olcc_bus_master.sv ----
`timescale 1ns/1ns
module olcc_bus_master (
    input  wire logic        clk,
    input  wire logic        wbAck,
    output logic             wbCyc,
    output logic             wbStb,
    output logic             wbWe,
    output logic [6:0]       wbAdr,
    output logic [3:0]       wbSel,
    output logic [31:0]      wbDatW,
    output logic             busTimeout
);
    // idle bus at time zero
    initial begin
        {wbCyc, wbStb, wbWe, busTimeout} = 4'h0;
        wbAdr = 7'h7F;
        wbSel = 4'hF;
        wbDatW = 32'hFFFF_FFFF;
    end
    // one classic cycle, held until ack is sampled high; clear and writes pass here
    task automatic access(input logic we, input logic [4:0] idx, input logic [7:0] data);
        int n;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'b00};
        wbDatW <= {24'h000000, data};
        n = 0;
        @(posedge clk);
        while (wbAck !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) busTimeout <= 1'b1;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        wbAdr <= ~wbAdr;
        wbDatW <= ~wbDatW;
        @(posedge clk);
    endtask : access
endmodule : olcc_bus_master

// ---- test/olcc_checker_props.sv ----
`timescale 1ns/1ns
module olcc_checker_props #(
    parameter int SETTLE_CYCLES = 20
) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire logic [6:0]           wb_adr_i,
    input wire logic [3:0]           wb_sel_i,
    input wire logic [31:0]          wb_dat_i,
    input wire logic                 wb_ack_o,
    input wire olcc_pkg::olcc_fuse_t fuseImage,
    input wire logic                 vregOk,
    input wire logic                 sdBitValid,
    input wire logic                 dataError,
    input wire logic                 deviceReset,
    input wire logic                 regulatorsOff
);
    import olcc_pkg::*;
    logic [15:0] relCnt_r;
    logic [7:0]  onCnt_r;
    logic [3:0]  clrAge_r;
    logic        clearWr;
    // accepted clear command on the bus
    assign clearWr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
                     && (wb_adr_i[6:2] == IDX_CTRL) && wb_dat_i[CTRL_CLEAR_BIT];
    // age since release, regulator-off width, age since last readout trigger
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            relCnt_r <= 16'h0000;
            onCnt_r  <= 8'h00;
            clrAge_r <= 4'hF;
        end else begin
            relCnt_r <= (relCnt_r == 16'hFFFF) ? relCnt_r : relCnt_r + 16'h0001;
            onCnt_r  <= regulatorsOff ? onCnt_r + 8'h01 : 8'h00;
            clrAge_r <= (clearWr || deviceReset) ? 4'h0 : ((clrAge_r == 4'hF) ? clrAge_r : clrAge_r + 4'h1);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered after one wait state");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge longer than one cycle");
    lock_gate_a: assert property ($rose(dataError) |-> fuseImage.factoryLock || fuseImage.deviceConfig2[7])
        else $error("data error raised with both fuse locks clear");
    error_hold_a: assert property ($fell(dataError) |-> clrAge_r < 4'h5)
        else $error("data error dropped without a readout");
    reset_hold_a: assert property (relCnt_r < SETTLE_CYCLES |-> deviceReset)
        else $error("internal reset released before settle time");
    supply_drop_a: assert property ($fell(vregOk) |-> ##[1:8] deviceReset)
        else $error("supply drop did not assert internal reset");
    cap_width_a: assert property ($fell(regulatorsOff) |-> onCnt_r == CAPTEST_TIME_CYC)
        else $error("regulator test pulse has wrong width");
    sd_rate_a: assert property (sdBitValid |=> !sdBitValid [*8])
        else $error("converter strobe repeats too fast");
    sd_quiet_a: assert property (deviceReset && $past(deviceReset) |-> !sdBitValid)
        else $error("converter strobe during internal reset");
    cover property ($rose(dataError));
    cover property (clearWr);
    cover property ($rose(regulatorsOff));
endmodule : olcc_checker_props

bind olcc_checker olcc_checker_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_olcc_checker_props (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .fuseImage(fuseImage), .vregOk(vregOk), .sdBitValid(sdBitValid), .dataError(dataError),
    .deviceReset(deviceReset), .regulatorsOff(regulatorsOff));

// ---- test/tb.sv ----
`timescale 1ns/1ns
module tb;
    import olcc_pkg::*;
    logic        clk, rst, wbCyc, wbStb, wbWe, wbAck, busTimeout, vregOk, sdBitIn = 1'b0, sawOff = 1'b0;
    logic        dataError, deviceReset, regulatorsOff, sdBitOut, sdBitValid;
    logic [6:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatW, wbDatR;
    olcc_fuse_t  fuseImage;
    logic [31:0] expQ[$];
    string       nameQ[$];
    int          n_fail = 0;
    int          n_compared = 0;
    int          sdCnt = 0;

    olcc_checker #(.SETTLE_CYCLES(20), .CAPTEST_RATE(300)) u_olcc_checker (
        .clk(clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .fuseImage(fuseImage),
        .reservoirSupplyOk(1'b1), .vregOk(vregOk), .vregaOk(1'b1), .sdBitIn(sdBitIn), .sdBitOut(sdBitOut),
        .sdBitValid(sdBitValid), .dataError(dataError), .deviceReset(deviceReset), .regulatorsOff(regulatorsOff));
    olcc_bus_master u_olcc_bus_master (
        .clk(clk), .wbAck(wbAck), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbSel(wbSel), .wbDatW(wbDatW), .busTimeout(busTimeout));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask : check
    // three-bit code, lsb of the stream first
    function automatic logic [2:0] code(input olcc_fuse_t f, input logic usr);
        logic [73:0] s;
        logic [2:0]  c;
        logic        fb;
        s = usr ? {f.userDataBytes, f.deviceConfig2[5], f.deviceConfig2[3:0], f.deviceConfig1[1:0],
                   f.deviceConfig0[7], f.typeReg[7:6]} : {28'h0, f.factoryCfg, f.typeReg[5:0], f.serialNumber};
        c = 3'h7;
        for (int i = 0; i < (usr ? 74 : 46); i++) begin
            fb = c[2] ^ s[i];
            c = {c[1], c[0] ^ fb, fb};
        end
        return c;
    endfunction : code
    function automatic logic [31:0] calc(input olcc_fuse_t f);
        return {21'h0, code(f, 1'b1), 5'h00, code(f, 1'b0)};
    endfunction : calc
    task automatic rd(input logic [4:0] idx, input logic [31:0] exp, input string what);
        expQ.push_back(exp);
        nameQ.push_back(what);
        u_olcc_bus_master.access(1'b0, idx, 8'h00);
    endtask : rd
    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        u_olcc_bus_master.access(1'b1, idx, d);
    endtask : wr
    task automatic clear();
        wr(IDX_CTRL, 8'h01);
        repeat (4) @(posedge clk);
    endtask : clear
    task automatic waitRun();
        int n;
        n = 0;
        while (deviceReset !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n == 200) begin
            n_fail++;
            finish_test();
        end
        repeat (5) @(posedge clk);
    endtask : waitRun
    // read answers are compared with the oldest note
    always @(posedge clk) begin
        if (wbAck === 1'b1 && wbWe === 1'b0) check(nameQ.pop_front(), wbDatR, expQ.pop_front());
        if (regulatorsOff === 1'b1) sawOff <= 1'b1;
        sdCnt <= sdCnt + 1;
        if (sdCnt % 100 == 0) sdBitIn <= 1'($urandom());
        if (sdBitValid === 1'b1 && sdCnt % 100 > 10) check("sdBitOut", 32'(sdBitOut), 32'(sdBitIn));
        if (busTimeout === 1'b1) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        olcc_fuse_t img, bad;
        int         n;
        void'($urandom(76319));
        img = '0;
        img.serialNumber = $urandom();
        img.typeReg = 8'($urandom());
        img.factoryCfg = 8'($urandom());
        img.deviceConfig0 = 8'($urandom());
        img.deviceConfig1 = 8'($urandom());
        img.deviceConfig2 = 8'($urandom()) & 8'h7F;
        img.userDataBytes = {$urandom(), $urandom()};
        img.factoryLock = 1'b1;
        img.factoryCrc = code(img, 1'b0);
        {rst, vregOk} = 2'h3;
        fuseImage = img;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        waitRun();
        rd(IDX_STATUS, 32'h02, "status after power-on");
        rd(IDX_CALC, calc(img), "computed codes");
        img.userDataBytes[3] = 8'($urandom());
        wr(IDX_UDATA0 + 5'h03, img.userDataBytes[3]);
        rd(IDX_CALC, calc(img), "codes after user write");
        img.deviceConfig2[7] = 1'b1;
        wr(IDX_CFG2, img.deviceConfig2);
        rd(IDX_UCODE, {29'h0, code(img, 1'b1)}, "stored user code");
        rd(IDX_STATUS, 32'h02, "status lock inactive");
        img.userCode = code(img, 1'b1);
        fuseImage <= img;
        clear();
        rd(IDX_STATUS, 32'h06, "status user lock");
        wr(IDX_UDATA0, ~img.userDataBytes[0]);
        rd(IDX_STATUS, 32'h17, "status user mismatch");
        wr(IDX_UDATA0, img.userDataBytes[0]);
        rd(IDX_STATUS, 32'h07, "status sticky error");
        check("dataError", {31'h0, dataError}, 32'h1);
        clear();
        rd(IDX_STATUS, 32'h06, "status after clear");
        for (int d = 1; d < 8; d++) begin
            bad = img;
            bad.factoryCrc = bad.factoryCrc ^ 3'(d);
            fuseImage <= bad;
            clear();
            rd(IDX_STATUS, 32'h0F, "status factory mismatch");
        end
        fuseImage <= img;
        repeat (4) @(posedge clk);
        rd(IDX_STATUS, 32'h0F, "status mirror still bad");
        clear();
        bad.factoryLock = 1'b0;
        fuseImage <= bad;
        clear();
        rd(IDX_STATUS, 32'h04, "status factory unlocked");
        fuseImage <= img;
        vregOk <= 1'b0;
        n = 0;
        while (deviceReset !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        check("deviceReset", {31'h0, deviceReset}, 32'h1);
        if (n == 20) finish_test();
        vregOk <= 1'b1;
        waitRun();
        rd(IDX_STATUS, 32'h06, "status after supply return");
        repeat (400) @(posedge clk);
        check("regulator test seen", {31'h0, sawOff}, 32'h1);
        finish_test();
    end
endmodule : tb
